// *** common/dcf_consts.vh ***
// Constants for the configuration word decoder
`ifndef DCF_CONSTS_VH
`define DCF_CONSTS_VH

// ==================================================
// Configuration word layout
`define DCF_CFG_W 17
`define DCF_CFG_ERASED 17'h1ffff
`define DCF_B_CODE_PROT 0
`define DCF_B_WRITE_PROT 1
`define DCF_B_TWO_SPEED 2
`define DCF_B_PWM_LOCK 3
`define DCF_F_OSC_LO 4
`define DCF_F_OSC_HI 6
`define DCF_F_CSM_LO 7
`define DCF_F_CSM_HI 8
`define DCF_B_REMAP_ONCE 9
`define DCF_B_PIN2_FUNC 10
`define DCF_F_POSC_LO 11
`define DCF_F_POSC_HI 12
`define DCF_B_WDT_FUSE 13
`define DCF_B_WDT_WATCHDOG_WINDOW_DISABLE 14
`define DCF_B_PLL_LOCK 15
`define DCF_B_DEBUG_EN 16

// ==================================================
// Start-up oscillator codes
`define DCF_OSC_RC_DIVN 3'h7
`define DCF_OSC_RC_DIV16 3'h6
`define DCF_OSC_SLOW_RC 3'h5
`define DCF_OSC_RESERVED 3'h4
`define DCF_OSC_PRI_PLL 3'h3
`define DCF_OSC_PRI 3'h2
`define DCF_OSC_RC_PLL 3'h1
`define DCF_OSC_FAST_RC 3'h0

// ==================================================
// Primary oscillator modes
`define DCF_POSC_OFF 2'h3
`define DCF_POSC_FAST_XTAL 2'h2
`define DCF_POSC_STD_XTAL 2'h1
`define DCF_POSC_EXT_CLK 2'h0

// ==================================================
// Register byte addresses and fields
`define DCF_A_CFG_WORD 12'h000
`define DCF_A_STATUS 12'h004
`define DCF_A_RESET_CTRL 12'h008
`define DCF_A_PWM_KEY 12'h00c
`define DCF_A_REMAP_CTRL 12'h010
`define DCF_B_SOFT_WDT 0
`define DCF_B_REMAP_GO 0
`define DCF_PWM_KEY1 32'h0000abcd
`define DCF_PWM_KEY2 32'h00004321
`define DCF_RESET_CTRL_RST 1'h0

// ==================================================
// Load timing
`define DCF_LOAD_WAIT 2'h2

`endif

// *** rtl/dcf_sync2.v ***
// Two flip-flop synchroniser for a bus of levels
`default_nettype none
module dcf_sync2 #(
    parameter W = 1
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Data
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
reg [W-1:0] meta;

// ==================================================
// Synchroniser stages
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        meta <= {W{1'b0}};
        q <= {W{1'b0}};
    end else begin
        meta <= d;
        q <= meta;
    end
end
endmodule
`default_nettype wire

// *** rtl/dcf_osc_startup.v ***
// Start-up oscillator sequencer with two-speed start
`default_nettype none
`include "dcf_consts.vh"
module dcf_osc_startup (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Configuration
    input wire start,
    input wire two_speed,
    input wire [2:0] sel,
    input wire src_ready,
    // Status
    output reg [2:0] active_src,
    output reg on_selected
);
localparam S_IDLE = 2'h0;
localparam S_FAST_RC = 2'h1;
localparam S_SEL = 2'h2;

reg [1:0] state;
reg [1:0] next_state;
wire [2:0] target;

// Reserved code falls back to the fast RC source
assign target = (sel == `DCF_OSC_RESERVED) ? `DCF_OSC_FAST_RC : sel;

// ==================================================
// Next state
always @* begin
    next_state = state;
    case (state)
        S_IDLE: begin
            if (start) begin
                next_state = two_speed ? S_FAST_RC : S_SEL; // see R3
            end
        end
        S_FAST_RC: begin
            if (src_ready) begin
                next_state = S_SEL; // see R3
            end
        end
        S_SEL: next_state = S_SEL;
        default: next_state = S_IDLE;
    endcase
end

// ==================================================
// State and outputs
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        state <= S_IDLE;
        active_src <= `DCF_OSC_FAST_RC;
        on_selected <= 1'b0;
    end else begin
        state <= next_state;
        active_src <= (next_state == S_SEL) ? target : `DCF_OSC_FAST_RC; // see R5
        on_selected <= (next_state == S_SEL);
    end
end
endmodule
`default_nettype wire

// *** rtl/dcf_fuse_decode.v ***
// Configuration word decoder with APB register access
//
// Functional notes
// R1 - Code-protect bit 0 protects all program memory
// R2 - Write-protect bit 0 blocks program memory writes
// R3 - Two-speed start runs fast RC first
// R4 - PWM lock demands key before writes
// R5 - Oscillator select field picks start-up source
// R6 - Programmer must never use code 100
// R7 - Switch mode: 1x none, 01 switch, 00 both
// R8 - Remap lock bit allows one reconfiguration
// R9 - Second pin: clock out or GPIO, not crystal
// R10 - Primary mode: off, fast crystal, crystal, external clock
// R11 - Fuse watchdog always runs, slow RC stays on
// R12 - Otherwise software bit runs watchdog and slow RC
// R13 - Window disable 0 means window mode
// R14 - PLL lock bit enables lock gating
// R15 - Debug enable 1 turns on TMS pull-up
// R16 - Sample at reset, hold until next reset
`default_nettype none
`include "dcf_consts.vh"
module dcf_fuse_decode (
    // APB clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Non-volatile configuration word and clock status
    input wire [16:0] fuse_word,
    input wire selected_src_ready,
    // Events from the surrounding chip
    input wire pwm_write_done,
    // Memory protection
    output reg code_protect_en,
    output reg write_protect_en,
    // Oscillator control
    output reg [2:0] active_osc_src,
    output reg on_selected_src,
    output reg clock_switch_en,
    output reg fail_safe_monitor_en,
    output reg pll_lock_gate_en,
    output reg primary_osc_off,
    output reg primary_osc_fast_xtal,
    output reg primary_osc_std_xtal,
    output reg primary_osc_ext_clock,
    output reg second_pin_clock_out,
    output reg second_pin_gpio,
    // Peripheral locks
    output reg pwm_write_allow,
    output reg remap_update,
    output reg remap_locked,
    // Watchdog
    output reg watchdog_run,
    output reg slow_rc_keep_on,
    output reg watchdog_window_mode,
    // Debug port
    output reg debug_port_enable,
    output reg tms_pullup_en,
    // Load status
    output reg config_loaded
);

// ==================================================
// Declarations
wire [16:0] fuse_sync;
wire src_ready_sync;
reg [16:0] cfg_word;
reg [1:0] load_cnt;
reg soft_watchdog_enable;
reg pwm_key_stage;
reg pwm_unlocked;
reg remap_used;
wire [2:0] osc_src;
wire osc_on_sel;
wire crystal_mode;
wire apb_setup;
wire apb_access;
wire apb_done;
wire wr_en;
reg addr_ok;
reg [31:0] rd_val;

wire general_code_protect;
wire general_write_protect;
wire two_speed_startup_en;
wire pulse_width_reg_lock;
wire [2:0] startup_osc_select;
wire [1:0] clock_switch_monitor_mode;
wire remap_single_config;
wire second_osc_pin_function;
wire [1:0] primary_osc_mode_select;
wire watchdog_fuse_enable;
wire watchdog_window_disable;
wire pll_lock_en_bit;
wire debug_port_bit;

// ==================================================
// Input synchronisers
dcf_sync2 #(
    .W(`DCF_CFG_W)
) u_fuse_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(fuse_word),
    .q(fuse_sync)
);

dcf_sync2 #(
    .W(1)
) u_ready_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(selected_src_ready),
    .q(src_ready_sync)
);

// ==================================================
// Configuration capture after reset release
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        load_cnt <= 2'h0;
        config_loaded <= 1'b0;
        cfg_word <= `DCF_CFG_ERASED;
    end else if (!config_loaded) begin
        if (load_cnt == `DCF_LOAD_WAIT) begin
            cfg_word <= fuse_sync; // see R16
            config_loaded <= 1'b1;
        end else begin
            load_cnt <= load_cnt + 2'h1;
        end
    end
end

// ==================================================
// Field extraction
assign general_code_protect = cfg_word[`DCF_B_CODE_PROT];
assign general_write_protect = cfg_word[`DCF_B_WRITE_PROT];
assign two_speed_startup_en = cfg_word[`DCF_B_TWO_SPEED];
assign pulse_width_reg_lock = cfg_word[`DCF_B_PWM_LOCK];
assign startup_osc_select = cfg_word[`DCF_F_OSC_HI:`DCF_F_OSC_LO];
assign clock_switch_monitor_mode = cfg_word[`DCF_F_CSM_HI:`DCF_F_CSM_LO];
assign remap_single_config = cfg_word[`DCF_B_REMAP_ONCE];
assign second_osc_pin_function = cfg_word[`DCF_B_PIN2_FUNC];
assign primary_osc_mode_select = cfg_word[`DCF_F_POSC_HI:`DCF_F_POSC_LO];
assign watchdog_fuse_enable = cfg_word[`DCF_B_WDT_FUSE];
assign watchdog_window_disable = cfg_word[`DCF_B_WDT_WATCHDOG_WINDOW_DISABLE];
assign pll_lock_en_bit = cfg_word[`DCF_B_PLL_LOCK];
assign debug_port_bit = cfg_word[`DCF_B_DEBUG_EN];

assign crystal_mode = (primary_osc_mode_select == `DCF_POSC_FAST_XTAL) ||
                      (primary_osc_mode_select == `DCF_POSC_STD_XTAL);

// ==================================================
// Start-up oscillator sequencer
dcf_osc_startup u_osc_startup (
    .clk(pclk),
    .rst_n(presetn),
    .start(config_loaded),
    .two_speed(two_speed_startup_en),
    .sel(startup_osc_select),
    .src_ready(src_ready_sync),
    .active_src(osc_src),
    .on_selected(osc_on_sel)
);

// ==================================================
// Decoded controls, safe values until loaded
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        code_protect_en <= 1'b1;
        write_protect_en <= 1'b1;
        active_osc_src <= `DCF_OSC_FAST_RC;
        on_selected_src <= 1'b0;
        clock_switch_en <= 1'b0;
        fail_safe_monitor_en <= 1'b0;
        pll_lock_gate_en <= 1'b0;
        primary_osc_off <= 1'b1;
        primary_osc_fast_xtal <= 1'b0;
        primary_osc_std_xtal <= 1'b0;
        primary_osc_ext_clock <= 1'b0;
        second_pin_clock_out <= 1'b0;
        second_pin_gpio <= 1'b0;
        watchdog_run <= 1'b0;
        slow_rc_keep_on <= 1'b0;
        watchdog_window_mode <= 1'b0;
        debug_port_enable <= 1'b0;
        tms_pullup_en <= 1'b0;
    end else if (config_loaded) begin
        code_protect_en <= ~general_code_protect; // see R1
        write_protect_en <= ~general_write_protect; // see R2
        active_osc_src <= osc_src; // see R5
        on_selected_src <= osc_on_sel; // see R3
        clock_switch_en <= ~clock_switch_monitor_mode[1]; // see R7
        fail_safe_monitor_en <= (clock_switch_monitor_mode == 2'h0); // see R7
        pll_lock_gate_en <= pll_lock_en_bit; // see R14
        primary_osc_off <= (primary_osc_mode_select == `DCF_POSC_OFF); // see R10
        primary_osc_fast_xtal <= (primary_osc_mode_select == `DCF_POSC_FAST_XTAL); // see R10
        primary_osc_std_xtal <= (primary_osc_mode_select == `DCF_POSC_STD_XTAL); // see R10
        primary_osc_ext_clock <= (primary_osc_mode_select == `DCF_POSC_EXT_CLK); // see R10
        second_pin_clock_out <= ~crystal_mode & second_osc_pin_function; // see R9
        second_pin_gpio <= ~crystal_mode & ~second_osc_pin_function; // see R9
        watchdog_run <= watchdog_fuse_enable | soft_watchdog_enable; // see R11 R12
        slow_rc_keep_on <= watchdog_fuse_enable | soft_watchdog_enable; // see R11 R12
        watchdog_window_mode <= ~watchdog_window_disable; // see R13
        debug_port_enable <= debug_port_bit;
        tms_pullup_en <= debug_port_bit; // see R15
    end
end

// ==================================================
// APB phase decode
assign apb_setup = psel & ~penable;
assign apb_access = psel & penable;
assign apb_done = apb_access & pready;
assign wr_en = apb_done & pwrite & addr_ok;

always @* begin
    addr_ok = 1'b1;
    rd_val = 32'h0;
    case (paddr)
        `DCF_A_CFG_WORD: rd_val = {15'h0, cfg_word};
        `DCF_A_STATUS: rd_val = {26'h0, remap_used, pwm_unlocked, osc_on_sel,
            (startup_osc_select == `DCF_OSC_RESERVED), config_loaded, 1'b0}; // see R6
        `DCF_A_RESET_CTRL: rd_val = {31'h0, soft_watchdog_enable};
        `DCF_A_PWM_KEY: rd_val = 32'h0;
        `DCF_A_REMAP_CTRL: rd_val = {31'h0, remap_locked};
        default: addr_ok = 1'b0;
    endcase
end

// ==================================================
// APB answer, one wait state
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        prdata <= 32'h0;
        pslverr <= 1'b0;
    end else begin
        pready <= apb_access & ~pready;
        if (apb_access & ~pready) begin
            prdata <= pwrite ? 32'h0 : rd_val;
            pslverr <= ~addr_ok;
        end else if (apb_setup | ~psel) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
    end
end

// ==================================================
// Reset control register
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        soft_watchdog_enable <= `DCF_RESET_CTRL_RST;
    end else if (wr_en && paddr == `DCF_A_RESET_CTRL) begin
        soft_watchdog_enable <= pwdata[`DCF_B_SOFT_WDT]; // see R12
    end
end

// ==================================================
// PWM key sequence
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pwm_key_stage <= 1'b0;
        pwm_unlocked <= 1'b0;
        pwm_write_allow <= 1'b0;
    end else begin
        if (wr_en && paddr == `DCF_A_PWM_KEY) begin
            pwm_key_stage <= (pwdata == `DCF_PWM_KEY1);
        end
        if (wr_en && paddr == `DCF_A_PWM_KEY && pwm_key_stage && pwdata == `DCF_PWM_KEY2) begin
            pwm_unlocked <= 1'b1; // see R4
        end else if (pwm_write_done) begin
            pwm_unlocked <= 1'b0; // see R4
        end
        pwm_write_allow <= config_loaded &
            (~pulse_width_reg_lock | pwm_unlocked); // see R4
    end
end

// ==================================================
// Peripheral remap commit
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        remap_used <= 1'b0;
        remap_update <= 1'b0;
        remap_locked <= 1'b0;
    end else begin
        remap_update <= 1'b0;
        if (wr_en && paddr == `DCF_A_REMAP_CTRL &&
            pwdata[`DCF_B_REMAP_GO] && !remap_locked && config_loaded) begin
            remap_update <= 1'b1;
            remap_used <= 1'b1;
        end
        remap_locked <= config_loaded & remap_single_config &
            (remap_used | remap_update); // see R8
    end
end
endmodule
`default_nettype wire

// *** testbench/dcf_fuse_decode_properties.sv ***
// Concurrent checks on the configuration decoder ports
`default_nettype none
module dcf_fuse_decode_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Decoded controls
    input wire logic code_protect_en,
    input wire logic write_protect_en,
    input wire logic clock_switch_en,
    input wire logic fail_safe_monitor_en,
    input wire logic primary_osc_off,
    input wire logic primary_osc_fast_xtal,
    input wire logic primary_osc_std_xtal,
    input wire logic primary_osc_ext_clock,
    input wire logic second_pin_clock_out,
    input wire logic second_pin_gpio,
    input wire logic remap_update,
    input wire logic remap_locked,
    input wire logic watchdog_run,
    input wire logic slow_rc_keep_on,
    input wire logic debug_port_enable,
    input wire logic tms_pullup_en,
    input wire logic config_loaded
);
    // ==========================
    // Properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_monitor_needs_switch: assert property (fail_safe_monitor_en |-> clock_switch_en)
        else $error("monitor on without switching");
    a_primary_one_mode: assert property ($onehot({primary_osc_off, primary_osc_fast_xtal,
        primary_osc_std_xtal, primary_osc_ext_clock}))
        else $error("primary mode not one-hot");
    a_crystal_pin_idle: assert property ((primary_osc_fast_xtal || primary_osc_std_xtal)
        |-> !second_pin_clock_out && !second_pin_gpio)
        else $error("second pin used in crystal mode");
    a_pin_func_one: assert property (config_loaded && $past(config_loaded, 2)
        && (primary_osc_off || primary_osc_ext_clock) |-> second_pin_clock_out != second_pin_gpio)
        else $error("second pin function wrong");
    a_rc_with_wdt: assert property (slow_rc_keep_on == watchdog_run)
        else $error("slow clock keep-on differs from watchdog");
    a_tms_pullup: assert property (tms_pullup_en == debug_port_enable)
        else $error("pull-up differs from debug enable");
    a_decode_held: assert property (config_loaded && $past(config_loaded, 2)
        |-> $stable({code_protect_en, write_protect_en, clock_switch_en, fail_safe_monitor_en, primary_osc_off,
        debug_port_enable}))
        else $error("decoded controls changed");
    a_remap_once: assert property (remap_locked |-> !remap_update)
        else $error("remap after lock");
    a_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("wait state wrong");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_error_unmapped: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008,
        12'h00c, 12'h010}))
        else $error("error response wrong");

    c_loaded: cover property ($rose(config_loaded));
    c_remap: cover property (remap_update);
    c_slverr: cover property (pready && pslverr);
    c_wdt: cover property ($rose(watchdog_run));
endmodule

bind dcf_fuse_decode dcf_fuse_decode_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .code_protect_en(code_protect_en),
    .write_protect_en(write_protect_en), .clock_switch_en(clock_switch_en),
    .fail_safe_monitor_en(fail_safe_monitor_en), .primary_osc_off(primary_osc_off),
    .primary_osc_fast_xtal(primary_osc_fast_xtal), .primary_osc_std_xtal(primary_osc_std_xtal),
    .primary_osc_ext_clock(primary_osc_ext_clock), .second_pin_clock_out(second_pin_clock_out),
    .second_pin_gpio(second_pin_gpio), .remap_update(remap_update),
    .remap_locked(remap_locked), .watchdog_run(watchdog_run), .slow_rc_keep_on(slow_rc_keep_on),
    .debug_port_enable(debug_port_enable), .tms_pullup_en(tms_pullup_en), .config_loaded(config_loaded));
`default_nettype wire

// *** testbench/test_dcf_fuse_decode.sv ***
// Self-checking bench for the configuration word decoder
`default_nettype none
`include "dcf_consts.vh"
module test_dcf_fuse_decode;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================
    // Signals and design
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic selected_src_ready = 1, pwm_write_done = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [16:0] fuse_word = `DCF_CFG_ERASED;
    logic [2:0] active_osc_src;
    logic pready, pslverr, code_protect_en, write_protect_en, on_selected_src, clock_switch_en;
    logic fail_safe_monitor_en, pll_lock_gate_en, primary_osc_off, primary_osc_fast_xtal, primary_osc_std_xtal;
    logic primary_osc_ext_clock, second_pin_clock_out, second_pin_gpio, pwm_write_allow, remap_update, remap_locked;
    logic watchdog_run, slow_rc_keep_on, watchdog_window_mode, debug_port_enable, tms_pullup_en, config_loaded;
    int n_errors = 0, check_count = 0, n_upd = 0;

    dcf_fuse_decode u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .fuse_word, .selected_src_ready, .pwm_write_done, .code_protect_en, .write_protect_en,
        .active_osc_src, .on_selected_src, .clock_switch_en, .fail_safe_monitor_en, .pll_lock_gate_en,
        .primary_osc_off, .primary_osc_fast_xtal, .primary_osc_std_xtal, .primary_osc_ext_clock,
        .second_pin_clock_out, .second_pin_gpio,
        .pwm_write_allow, .remap_update, .remap_locked, .watchdog_run, .slow_rc_keep_on, .watchdog_window_mode,
        .debug_port_enable, .tms_pullup_en, .config_loaded);

    always #2 pclk = ~pclk;
    always @(posedge pclk) if (remap_update === 1'b1) n_upd <= n_upd + 1;

    // ==========================
    // Shared tasks
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge pclk);
            n++;
        end
        check("wait_states", n, 1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic boot(input logic [16:0] w);
        int n;
        n = 0;
        presetn <= 1'b0;
        fuse_word <= w;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        while (config_loaded !== 1'b1 && n < 8) begin
            @(posedge pclk);
            n++;
        end
        check("load_edges", n, 4);
        repeat (2) @(posedge pclk);
    endtask

    // ==========================
    // Scenarios
    task automatic t_decode();
        logic [16:0] w;
        logic [2:0] sel;
        logic xtal;
        logic [19:0] ex, gt;
        for (int i = 0; i < 9; i++) begin
            w = (i == 8) ? `DCF_CFG_ERASED : {i[0], i[1], i[2], i[0], i[2:1], i[1], i[2], i[1:0], i[2:0], i[0],
                i[2], i[1], i[0]};
            if (w[6:4] == 3'h4) begin
                w[6:4] = 3'h3;
            end
            boot(w);
            repeat (2) @(posedge pclk);
            sel = (w[6:4] == 3'h4) ? 3'h0 : w[6:4];
            xtal = w[12:11] == 2'h1 || w[12:11] == 2'h2;
            ex = {~w[0], ~w[1], sel, ~w[8], w[8:7] == 2'h0, w[15], w[12:11] == 2'h3, w[12:11] == 2'h2,
                w[12:11] == 2'h1, w[12:11] == 2'h0, w[10] & ~xtal, ~w[10] & ~xtal, ~w[3], w[13], w[13], ~w[14],
                w[16], w[16]};
            for (int j = 0; j < 2; j++) begin
                gt = {code_protect_en, write_protect_en, active_osc_src, clock_switch_en, fail_safe_monitor_en,
                    pll_lock_gate_en, primary_osc_off, primary_osc_fast_xtal, primary_osc_std_xtal,
                    primary_osc_ext_clock, second_pin_clock_out, second_pin_gpio, pwm_write_allow, watchdog_run,
                    slow_rc_keep_on, watchdog_window_mode,
                    debug_port_enable, tms_pullup_en};
                check("decode", gt, ex);
                fuse_word <= ~w;
                repeat (4) @(posedge pclk);
            end
            apb(1'b0, `DCF_A_CFG_WORD, 32'h0);
            check("cfg_word", rd, {15'h0, w});
        end
    endtask

    task automatic t_twospeed();
        int n;
        n = 0;
        selected_src_ready <= 1'b0;
        boot(17'h1ffaf);
        check("fast_rc_first", {on_selected_src, active_osc_src}, 4'h0);
        selected_src_ready <= 1'b1;
        while (on_selected_src !== 1'b1 && n < 8) begin
            @(posedge pclk);
            n++;
        end
        @(posedge pclk);
        check("switched", {on_selected_src, active_osc_src}, 4'ha);
        selected_src_ready <= 1'b0;
        boot(17'h1ffab);
        check("direct_start", active_osc_src, 3'h2);
        selected_src_ready <= 1'b1;
    endtask

    task automatic t_regs();
        boot(17'h1dfff);
        apb(1'b1, `DCF_A_RESET_CTRL, 32'h1);
        repeat (2) @(posedge pclk);
        check("soft_on", {watchdog_run, slow_rc_keep_on}, 2'h3);
        apb(1'b0, `DCF_A_RESET_CTRL, 32'h0);
        check("soft_rd", rd, 32'h1);
        apb(1'b1, `DCF_A_RESET_CTRL, 32'h0);
        repeat (2) @(posedge pclk);
        check("soft_off", {watchdog_run, slow_rc_keep_on}, 2'h0);
        apb(1'b1, 12'h014, 32'h1);
        check("unmapped_wr", err, 1'b1);
        apb(1'b1, `DCF_A_CFG_WORD, 32'h0);
        check("ro_wr_err", err, 1'b0);
        apb(1'b0, `DCF_A_CFG_WORD, 32'h0);
        check("ro_kept", rd, 32'h1dfff);
        boot(`DCF_CFG_ERASED);
        apb(1'b1, `DCF_A_RESET_CTRL, 32'h0);
        repeat (2) @(posedge pclk);
        check("fuse_wdt", {watchdog_run, slow_rc_keep_on}, 2'h3);
        apb(1'b0, `DCF_A_STATUS, 32'h0);
        check("loaded_bit", rd[1], 1'b1);
    endtask

    task automatic t_pwm();
        boot(`DCF_CFG_ERASED);
        apb(1'b1, `DCF_A_PWM_KEY, `DCF_PWM_KEY1);
        apb(1'b1, `DCF_A_PWM_KEY, 32'h0);
        apb(1'b1, `DCF_A_PWM_KEY, `DCF_PWM_KEY2);
        repeat (2) @(posedge pclk);
        check("bad_key", pwm_write_allow, 1'b0);
        apb(1'b1, `DCF_A_PWM_KEY, `DCF_PWM_KEY1);
        apb(1'b1, `DCF_A_PWM_KEY, `DCF_PWM_KEY2);
        repeat (2) @(posedge pclk);
        check("unlocked", pwm_write_allow, 1'b1);
        pwm_write_done <= 1'b1;
        @(posedge pclk);
        pwm_write_done <= 1'b0;
        repeat (3) @(posedge pclk);
        check("relocked", pwm_write_allow, 1'b0);
    endtask

    task automatic t_remap(input logic [16:0] w, input int pulses);
        int s;
        boot(w);
        s = n_upd;
        apb(1'b1, `DCF_A_REMAP_CTRL, 32'h1);
        apb(1'b1, `DCF_A_REMAP_CTRL, 32'h1);
        apb(1'b0, `DCF_A_REMAP_CTRL, 32'h0);
        check("remap_pulses", n_upd - s, pulses);
        check("remap_lock", {remap_locked, rd[0]}, {2{w[9]}});
    endtask

    // ==========================
    // Sequence and verdict
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #40us;
        n_errors++;
        give_verdict();
    end

    initial begin
        @(posedge pclk);
        t_decode();
        $display("decode table done");
        t_twospeed();
        $display("two-speed start done");
        t_regs();
        $display("registers done");
        t_pwm();
        $display("pwm key done");
        t_remap(`DCF_CFG_ERASED, 1);
        t_remap(17'h1fdff, 2);
        $display("remap done");
        give_verdict();
    end
endmodule
`default_nettype wire
